// ==== design/gli_pkg.sv ====
package gli_pkg;

  // ==========================================================================
  // pin layout
  // ==========================================================================
  localparam int GLI_PIN_COUNT  = 3;
  localparam int GLI_MODE_W     = 2;
  localparam int GLI_PIN_SPEED  = 0;   // speed indicator position
  localparam int GLI_PIN_LINK   = 1;   // link and activity indicator position
  localparam int GLI_PIN_DUPLEX = 2;   // duplex indicator position

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int GLI_CLK_HZ       = 10_000_000;
  localparam int GLI_PHASE_MS     = 80;
  // whole cycles per indicator phase, 800000 at 10 MHz
  localparam int GLI_PHASE_CYCLES = (GLI_CLK_HZ / 1000) * GLI_PHASE_MS;
  localparam int GLI_CNT_W        = 20;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef logic [GLI_CNT_W-1:0]     gli_cnt_t;
  typedef logic [GLI_PIN_COUNT-1:0] gli_pins_t;

  typedef enum logic [1:0] {
    GLI_MODE_INPUT      = 2'h0,
    GLI_MODE_PUSH_PULL  = 2'h1,
    GLI_MODE_OPEN_DRAIN = 2'h2
  } gli_mode_e;

  // one-bit steps idle -> blank -> hold; hold -> idle flips both bits
  typedef enum logic [1:0] {
    GLI_ST_IDLE  = 2'h0,
    GLI_ST_BLANK = 2'h1,
    GLI_ST_HOLD  = 2'h3
  } gli_blink_e;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam gli_pins_t  GLI_PINS_RST  = 3'h0;
  localparam gli_cnt_t   GLI_CNT_RST   = 20'h00000;
  localparam gli_blink_e GLI_STATE_RST = GLI_ST_IDLE;

endpackage : gli_pkg

// ==== design/gli_blink_if.sv ====
`timescale 1ns/1ns
// activity blink request and answer between the pin logic and the timer
interface gli_blink_if;
  logic link_valid;
  logic activity;
  logic blank;

  modport timer (input link_valid, input activity, output blank);
  modport user  (output link_valid, output activity, input blank);
endinterface : gli_blink_if

// ==== design/gli_blink.sv ====
`timescale 1ns/1ns
module gli_blink #(
  parameter int unsigned PHASE_CYCLES = gli_pkg::GLI_PHASE_CYCLES
) (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset_n,
  // link side of the pin logic
  gli_blink_if.timer  bus
);
  import gli_pkg::*;

  localparam gli_cnt_t CNT_LAST = gli_cnt_t'(PHASE_CYCLES - 1);

  gli_blink_e state;
  gli_blink_e next_state;
  gli_cnt_t   cnt;
  gli_cnt_t   next_cnt;
  logic       pending;
  logic       next_pending;
  logic       blank;
  logic       next_blank;

  // ==========================================================================
  // phase sequencer
  // ==========================================================================
  // activity seen while blanking or holding is remembered, so a burst that
  // lands mid-cycle still earns another flash after the minimum lit time
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_pending = pending | bus.activity;     // a fresh event beats the clear
    case (state)
      GLI_ST_IDLE: begin
        next_cnt     = GLI_CNT_RST;
        next_pending = 1'b0;
        if (bus.activity) begin
          next_state = GLI_ST_BLANK;
        end
      end
      GLI_ST_BLANK: begin
        if (cnt == CNT_LAST) begin
          next_cnt   = GLI_CNT_RST;
          next_state = GLI_ST_HOLD;
        end else begin
          next_cnt = cnt + 20'h00001;
        end
      end
      GLI_ST_HOLD: begin
        if (cnt == CNT_LAST) begin
          next_cnt     = GLI_CNT_RST;
          next_state   = next_pending ? GLI_ST_BLANK : GLI_ST_IDLE;
          next_pending = 1'b0;
        end else begin
          next_cnt = cnt + 20'h00001;
        end
      end
      default: begin
        next_state   = GLI_ST_IDLE;
        next_cnt     = GLI_CNT_RST;
        next_pending = 1'b0;
      end
    endcase
    // no link, no flashing: the indicator goes solid off elsewhere
    if (!bus.link_valid) begin
      next_state   = GLI_ST_IDLE;
      next_cnt     = GLI_CNT_RST;
      next_pending = 1'b0;
    end
    next_blank = (next_state == GLI_ST_BLANK);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state   <= GLI_STATE_RST;
      cnt     <= GLI_CNT_RST;
      pending <= 1'b0;
      blank   <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      pending <= next_pending;
      blank   <= next_blank;
    end
  end

  assign bus.blank = blank;

  // ==========================================================================
  // checks
  // ==========================================================================
  a_blank_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == GLI_ST_IDLE && bus.link_valid && bus.activity) |=> blank)
    else $error("blank did not start after activity");

  a_blank_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($fell(blank) && $past(bus.link_valid)) |-> ($past(cnt) == CNT_LAST))
    else $error("blank phase ended early");

  a_hold_minimum: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == GLI_ST_HOLD && bus.link_valid && cnt != CNT_LAST) |=> state == GLI_ST_HOLD)
    else $error("lit hold ended before its minimum");

  a_nolink_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !bus.link_valid |=> !blank)
    else $error("blank while no link");

endmodule : gli_blink

// ==== design/gli_top.sv ====
`timescale 1ns/1ns
module gli_top #(
  parameter int unsigned PHASE_CYCLES = gli_pkg::GLI_PHASE_CYCLES
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // pin configuration, two mode bits per pin
  input  wire logic [5:0]        pin_mode,
  input  wire gli_pkg::gli_pins_t pin_out_data,
  input  wire gli_pkg::gli_pins_t indicator_enable,
  // link status from the physical layer
  input  wire logic              link_up,
  input  wire logic              speed_100,
  input  wire logic              autoneg_busy,
  input  wire logic              full_duplex,
  input  wire logic              tx_activity,
  input  wire logic              rx_activity,
  // general_indicator_pins
  input  wire gli_pkg::gli_pins_t general_indicator_pins_in,
  output      gli_pkg::gli_pins_t general_indicator_pins_out,
  output      gli_pkg::gli_pins_t general_indicator_pins_oe,
  // pin level readback
  output      gli_pkg::gli_pins_t pin_in_data
);
  import gli_pkg::*;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // open-drain drive as {oe, out}: low pulls, high releases
  function automatic logic [1:0] od_drive(input logic level);
    od_drive = level ? 2'h0 : 2'h2;
  endfunction : od_drive

  // mode field of one pin; the unused code falls back to input
  function automatic gli_mode_e mode_of(input logic [5:0] modes, input int idx);
    logic [1:0] raw;
    raw = modes[idx*GLI_MODE_W +: GLI_MODE_W];
    case (raw)
      2'h1:    mode_of = GLI_MODE_PUSH_PULL;
      2'h2:    mode_of = GLI_MODE_OPEN_DRAIN;
      default: mode_of = GLI_MODE_INPUT;
    endcase
  endfunction : mode_of

  // ==========================================================================
  // activity timer
  // ==========================================================================
  gli_blink_if u_blink_bus ();

  assign u_blink_bus.link_valid = link_up;
  assign u_blink_bus.activity   = tx_activity | rx_activity;

  gli_blink #(
    .PHASE_CYCLES (PHASE_CYCLES)
  ) u_blink (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .bus     (u_blink_bus.timer)
  );

  // ==========================================================================
  // indicator levels, active low
  // ==========================================================================
  gli_pins_t ind_level;
  logic      at_100;
  logic      duplex_full;

  // negotiation wins over a stale speed bit so the led never lies mid-handshake
  always_comb begin
    at_100      = link_up & speed_100 & ~autoneg_busy;
    duplex_full = link_up & full_duplex & ~autoneg_busy;
    ind_level   = GLI_PINS_RST;
    ind_level[GLI_PIN_SPEED]  = ~at_100;
    ind_level[GLI_PIN_LINK]   = ~link_up | u_blink_bus.blank;
    ind_level[GLI_PIN_DUPLEX] = ~duplex_full;
  end

  // ==========================================================================
  // pin drivers
  // ==========================================================================
  gli_pins_t next_pins_out;
  gli_pins_t next_pins_oe;
  gli_pins_t next_pin_in_data;

  // indicator use overrides the general setting of the same pin
  always_comb begin
    logic [1:0] drv;
    drv              = 2'h0;
    next_pins_out    = GLI_PINS_RST;
    next_pins_oe     = GLI_PINS_RST;
    next_pin_in_data = general_indicator_pins_in;
    for (int i = 0; i < GLI_PIN_COUNT; i++) begin
      if (indicator_enable[i]) begin
        drv = od_drive(ind_level[i]);
      end else begin
        case (mode_of(pin_mode, i))
          GLI_MODE_PUSH_PULL:  drv = {1'b1, pin_out_data[i]};
          GLI_MODE_OPEN_DRAIN: drv = od_drive(pin_out_data[i]);
          default:             drv = 2'h0;
        endcase
      end
      next_pins_oe[i]  = drv[1];
      next_pins_out[i] = drv[0];
    end
  end

  // registered so the pads never see decode glitches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      general_indicator_pins_out <= GLI_PINS_RST;
      general_indicator_pins_oe  <= GLI_PINS_RST;
      pin_in_data                <= GLI_PINS_RST;
    end else begin
      general_indicator_pins_out <= next_pins_out;
      general_indicator_pins_oe  <= next_pins_oe;
      pin_in_data                <= next_pin_in_data;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  a_push_pull_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[0] && pin_mode[1:0] == 2'h1)
      |=> (general_indicator_pins_oe[0]
           && general_indicator_pins_out[0] == $past(pin_out_data[0])))
    else $error("push-pull pin not driving its data");

  a_input_released: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[1] && pin_mode[3:2] == 2'h0) |=> !general_indicator_pins_oe[1])
    else $error("input pin is being driven");

  a_indicator_od: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (|indicator_enable) |=> ((general_indicator_pins_out & $past(indicator_enable)) == 3'h0))
    else $error("indicator pin driven high");

  a_speed_lit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[0] && link_up && speed_100 && !autoneg_busy)
      |=> general_indicator_pins_oe[0])
    else $error("speed indicator dark at 100 Mb");

  a_speed_dark: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[0] && (!link_up || !speed_100 || autoneg_busy))
      |=> !general_indicator_pins_oe[0])
    else $error("speed indicator lit off 100 Mb");

  a_link_solid: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[1] && link_up && !u_blink_bus.blank) |=> general_indicator_pins_oe[1])
    else $error("link indicator dark on a quiet link");

  a_duplex_lit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[2] && link_up && full_duplex && !autoneg_busy)
      |=> general_indicator_pins_oe[2])
    else $error("duplex indicator dark in full duplex");

  a_duplex_dark: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[2] && (!link_up || !full_duplex)) |=> !general_indicator_pins_oe[2])
    else $error("duplex indicator lit without full duplex");

  a_push_pull_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[1] && pin_mode[3:2] == 2'h1)
      |=> (general_indicator_pins_oe[1]
           && general_indicator_pins_out[1] == $past(pin_out_data[1])))
    else $error("second push-pull pin not driving its data");

  a_push_pull_two: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[2] && pin_mode[5:4] == 2'h1)
      |=> (general_indicator_pins_oe[2]
           && general_indicator_pins_out[2] == $past(pin_out_data[2])))
    else $error("third push-pull pin not driving its data");

  a_open_drain_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[0] && pin_mode[1:0] == 2'h2)
      |=> (general_indicator_pins_oe[0] == !$past(pin_out_data[0])
           && !general_indicator_pins_out[0]))
    else $error("first open-drain pin not pulling on low data");

  a_open_drain_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[1] && pin_mode[3:2] == 2'h2)
      |=> (general_indicator_pins_oe[1] == !$past(pin_out_data[1])
           && !general_indicator_pins_out[1]))
    else $error("second open-drain pin not pulling on low data");

  a_open_drain_two: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[2] && pin_mode[5:4] == 2'h2)
      |=> (general_indicator_pins_oe[2] == !$past(pin_out_data[2])
           && !general_indicator_pins_out[2]))
    else $error("third open-drain pin not pulling on low data");

  // the spare mode code must behave as a plain input
  a_input_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[0] && (pin_mode[1:0] == 2'h0 || pin_mode[1:0] == 2'h3))
      |=> !general_indicator_pins_oe[0])
    else $error("first pin driven while an input");

  a_input_two: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!indicator_enable[2] && (pin_mode[5:4] == 2'h0 || pin_mode[5:4] == 2'h3))
      |=> !general_indicator_pins_oe[2])
    else $error("third pin driven while an input");

  // reset_n in the antecedent keeps the release edge from comparing a reset value
  a_readback_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_n |=> (pin_in_data == $past(general_indicator_pins_in)))
    else $error("pin readback not one cycle behind the pins");

  a_link_dark: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[1] && !link_up) |=> !general_indicator_pins_oe[1])
    else $error("link indicator lit without a link");

  a_flash_dark: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[1] && link_up && u_blink_bus.blank)
      |=> !general_indicator_pins_oe[1])
    else $error("link indicator lit during a flash");

  a_duplex_negotiating: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (indicator_enable[2] && autoneg_busy) |=> !general_indicator_pins_oe[2])
    else $error("duplex indicator lit while negotiating");

endmodule : gli_top

// ==== dv/gli_led_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// led with pull-up on each pin, plus an outside driver
// ==========================================================
module gli_led_model
  import gli_pkg::*;
(
  // device side of the pins
  input  wire gli_pkg::gli_pins_t pin_out,
  input  wire gli_pkg::gli_pins_t pin_oe,
  // outside driver, only on pins the device has released
  input  wire logic               ext_en,
  input  wire gli_pkg::gli_pins_t ext_val,
  // resolved wire level, low means lit
  output gli_pkg::gli_pins_t      pin_lvl
);
  // pull-up wins where nobody drives, so a released line never keeps a stale value
  always_comb begin
    for (int i = 0; i < GLI_PIN_COUNT; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en ? ext_val[i] : 1'b1);
    end
  end
endmodule : gli_led_model

// ==== dv/gli_top_test.sv ====
`timescale 1ns/1ns
module gli_top_test;
  import gli_pkg::*;
  // ==========================================================
  // bench signals
  // ==========================================================
  localparam int P = 8;   // short phase so the flash fits the run
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic [5:0] pin_mode = 6'h0;
  gli_pins_t pin_out_data = 3'h0, indicator_enable = 3'h0, ext_val = 3'h0;
  logic link_up = 1'b0, speed_100 = 1'b0, autoneg_busy = 1'b0, full_duplex = 1'b0;
  logic tx_activity = 1'b0, rx_activity = 1'b0, ext_en = 1'b0;
  gli_pins_t pin_out, pin_oe, pin_lvl, pin_in_data;
  int n_fail = 0, total_checks = 0, cycles = 0;

  always #50 clk_sys = ~clk_sys;

  gli_top #(.PHASE_CYCLES(P)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .pin_mode(pin_mode), .pin_out_data(pin_out_data), .indicator_enable(indicator_enable),
    .link_up(link_up), .speed_100(speed_100), .autoneg_busy(autoneg_busy),
    .full_duplex(full_duplex), .tx_activity(tx_activity), .rx_activity(rx_activity),
    .general_indicator_pins_in(pin_lvl), .general_indicator_pins_out(pin_out),
    .general_indicator_pins_oe(pin_oe), .pin_in_data(pin_in_data));

  gli_led_model i_led (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(pin_lvl));

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // sample a little after the edge so its updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // run lengths in cycles, wide enough that a long run cannot alias a short one
  task automatic chk_n(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : chk_n

  // cycles the link pin stays at v, capped so a stuck pin cannot hang
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (pin_lvl[1] === v && n < 40) begin
      wt(1);
      n++;
    end
  endtask : run_len

  // ==========================================================
  // scenarios
  // ==========================================================
  // every pin in a different mode code, every data pattern
  task automatic chk_modes();
    logic [1:0] m;
    logic [2:0] eo, ev, lv, dd;
    for (int k = 0; k < 4; k++) begin
      for (int d = 0; d < 8; d++) begin
        dd = 3'(d);
        @(posedge clk_sys);
        ext_en <= 1'b1;
        ext_val <= ~dd;
        pin_mode <= {2'(k + 2), 2'(k + 1), 2'(k)};
        pin_out_data <= dd;
        wt(2);
        for (int i = 0; i < 3; i++) begin
          m = 2'(k + i);
          eo[i] = (m == 2'h1) || (m == 2'h2 && !dd[i]);
          ev[i] = (m == 2'h1) ? dd[i] : 1'b0;
          lv[i] = eo[i] ? ev[i] : ~dd[i];
        end
        chk("pin enable", eo, pin_oe);
        chk("pin drive", ev, pin_out & eo);
        wt(1);
        chk("pin readback", lv, pin_in_data);
      end
    end
  endtask : chk_modes

  // all status combinations with the pins set push-pull high underneath
  task automatic chk_indicators();
    logic l, s, a, f;
    @(posedge clk_sys);
    ext_en <= 1'b0;
    pin_mode <= 6'h15;
    pin_out_data <= 3'h7;
    indicator_enable <= 3'h7;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      {link_up, speed_100, autoneg_busy, full_duplex} <= 4'(k);
      wt(2);
      {l, s, a, f} = 4'(k);
      chk("speed pin", 3'(!(l & s & !a)), 3'(pin_lvl[0]));
      chk("link pin", 3'(!l), 3'(pin_lvl[1]));
      chk("duplex pin", 3'(!(l & f & !a)), 3'(pin_lvl[2]));
      chk("indicator drive", 3'h0, pin_out);
    end
  endtask : chk_indicators

  // tx flash, rx seen mid-flash remembered once, then solid again
  task automatic chk_activity();
    int n;
    @(posedge clk_sys);
    link_up <= 1'b1;
    autoneg_busy <= 1'b0;
    wt(2);
    chk("link lit", 3'h0, 3'(pin_lvl[1]));
    @(posedge clk_sys);
    tx_activity <= 1'b1;
    @(posedge clk_sys);
    tx_activity <= 1'b0;
    wt(1);
    chk("flash start", 3'h1, 3'(pin_lvl[1]));
    @(posedge clk_sys);
    rx_activity <= 1'b1;
    @(posedge clk_sys);
    rx_activity <= 1'b0;
    wt(1);
    run_len(1'b1, n);
    chk_n("dark length", 8'(P - 3), 8'(n));
    run_len(1'b0, n);
    chk("lit minimum", 3'h1, 3'(n >= P && n <= P + 2));
    run_len(1'b1, n);
    chk_n("second dark", 8'(P), 8'(n));
    run_len(1'b0, n);
    chk("no repeat", 3'h1, 3'(n == 40));
    // a link drop mid-flash must cancel it, so the returning link shows solid
    @(posedge clk_sys);
    tx_activity <= 1'b1;
    @(posedge clk_sys);
    tx_activity <= 1'b0;
    link_up <= 1'b0;
    @(posedge clk_sys);
    link_up <= 1'b1;
    wt(2);
    chk("flash aborted", 3'h0, 3'(pin_lvl[1]));
  endtask : chk_activity

  // ==========================================================
  // run
  // ==========================================================
  // hang guard, far above the few hundred cycles the scenarios need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk_modes();
    chk_indicators();
    chk_activity();
    close_out();
  end
endmodule : gli_top_test
